/* File: core/e1nb_irq.sv */
`timescale 1ns/100ps
module e1nb_irq (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [e1nb_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire e1nb_pkg::e1nb_rx_t rx,
	output logic irq
);
	import e1nb_pkg::*;

	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;
	logic [3:0] raw_r;
	logic [3:0] deb_r;
	logic [3:0] dq_r;
	logic [1:0] cnt_r;
	logic [2:0] hist_r;
	logic sa7z_r;
	logic exz_r;
	logic sa7_maj;
	logic [SA_W-1:0] sa_en_r;
	logic [SA_W-1:0] sa_sts_r;
	logic [SA_W-1:0] sa_sts_nxt;
	logic [SA_W-1:0] sa_evt;
	logic [SA_W-1:0] sa_clr;
	logic [SA_W-1:0] hit_now;
	logic [SA_W-1:0] hit_old;
	logic [EZ_W-1:0] ez_en_r;
	logic [EZ_W-1:0] ez_sts_r;
	logic [EZ_W-1:0] ez_sts_nxt;
	logic [EZ_W-1:0] ez_evt;
	logic [EZ_W-1:0] ez_clr;
	logic acc;
	logic done;
	logic [13:0] idx;
	logic [31:0] rd_val;
	logic rd_err;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;

	// ********************************
	// Sa6 debounce and pattern events
	// ********************************

	// Which monitored pattern a nibble matches; other means none of them
	function automatic logic [SA_W-1:0] pat_hits(input logic [3:0] v);
		pat_hits[BIT_PAT_A] = (v == PAT_A);
		pat_hits[BIT_PAT_B] = (v == PAT_B);
		pat_hits[BIT_PAT_C] = ((v & PAT_C_MASK) == PAT_C);
		pat_hits[BIT_ZERO] = (v == PAT_ZERO);
		pat_hits[BIT_OTHER] = ~(pat_hits[BIT_PAT_A] | pat_hits[BIT_PAT_B] |
			pat_hits[BIT_PAT_C] | pat_hits[BIT_ZERO]);
	endfunction : pat_hits

	assign hit_now = pat_hits(deb_r);
	assign hit_old = pat_hits(dq_r);

	// Same nibble DEB_CNT times in a row before it is believed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_r <= SA6_RST;
			cnt_r <= 2'h0;
			deb_r <= SA6_RST;
		end else if (rx.sa6_valid) begin
			raw_r <= rx.sa6;
			if (rx.sa6 != raw_r) begin
				cnt_r <= 2'h0;
			end else if (cnt_r != DEB_LAST) begin
				cnt_r <= cnt_r + 2'h1;
			end
			if (rx.sa6 == raw_r && cnt_r == DEB_LAST - 2'h1) begin
				deb_r <= rx.sa6;
			end
		end
	end

	// Previous debounced value, the reference for change detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_r <= SA6_RST;
		end else begin
			dq_r <= deb_r;
		end
	end

	// Entry and exit both flip the match, so xor catches both edges
	always_comb begin
		sa_evt = hit_now ^ hit_old;
		// Other fires on each new unmatched value, not on leaving it
		sa_evt[BIT_OTHER] = (deb_r != dq_r) && hit_now[BIT_OTHER];
	end

	// ********************************
	// Sa7 majority and excessive zero
	// ********************************

	// Two or more zeros among the last three Sa7 samples
	assign sa7_maj = (~hist_r[0] & ~hist_r[1]) | (~hist_r[0] & ~hist_r[2]) |
		(~hist_r[1] & ~hist_r[2]);

	// History starts all ones so reset does not declare the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_r <= SA7_HIST_RST;
		end else if (rx.sa7_valid) begin
			hist_r <= {hist_r[1:0], rx.sa7};
		end
	end

	// Registered state copies; a difference to the input is the event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sa7z_r <= 1'b0;
			exz_r <= 1'b0;
		end else begin
			sa7z_r <= sa7_maj;
			exz_r <= rx.exz;
		end
	end

	always_comb begin
		ez_evt[BIT_SA7_EVT] = sa7_maj != sa7z_r;
		ez_evt[BIT_EXZ_EVT] = rx.exz != exz_r;
	end

	// ********************************
	// APB slave
	// ********************************

	assign acc = psel & penable;
	assign done = acc & pready_r;
	assign idx = paddr[ADDR_W-1:2];

	// Read mux; reserved bits and write-only registers read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		case (idx)
			SA_STS_IDX: rd_val[SA_W-1:0] = sa_sts_r;
			SA_EN_IDX: rd_val[SA_W-1:0] = sa_en_r;
			EZ_STS_IDX: begin
				rd_val[BIT_SA7_STATE] = sa7z_r;
				rd_val[EZ_W-1:0] = ez_sts_r;
			end
			EZ_EN_IDX: rd_val[EZ_W-1:0] = ez_en_r;
			SA_CLR_IDX, EZ_CLR_IDX: rd_val = 32'h0000_0000;
			default: rd_err = 1'b1;
		endcase
	end

	// One wait state keeps prdata and pready straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (acc && !pready_r) begin
			pready_r <= 1'b1;
			pslverr_r <= rd_err;
			prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Enables load only at the completing edge of a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sa_en_r <= SA_EN_RST;
			ez_en_r <= EZ_EN_RST;
		end else if (done && pwrite) begin
			if (idx == SA_EN_IDX) begin
				sa_en_r <= pwdata[SA_W-1:0];
			end
			if (idx == EZ_EN_IDX) begin
				ez_en_r <= pwdata[EZ_W-1:0];
			end
		end
	end

	// ********************************
	// Sticky status and interrupt
	// ********************************

	// Clear only the bits already handed out, so late events survive
	always_comb begin
		sa_clr = '0;
		ez_clr = '0;
		if (done && !pwrite && idx == SA_STS_IDX) begin
			sa_clr = prdata_r[SA_W-1:0];
		end
		if (done && !pwrite && idx == EZ_STS_IDX) begin
			ez_clr = prdata_r[EZ_W-1:0];
		end
		if (done && pwrite && idx == SA_CLR_IDX) begin
			sa_clr = pwdata[SA_W-1:0];
		end
		if (done && pwrite && idx == EZ_CLR_IDX) begin
			ez_clr = pwdata[EZ_W-1:0];
		end
		// Set wins over clear in the same cycle
		sa_sts_nxt = (sa_sts_r & ~sa_clr) | sa_evt;
		ez_sts_nxt = (ez_sts_r & ~ez_clr) | ez_evt;
	end

	// Status latches every event; the enable only gates the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sa_sts_r <= '0;
			ez_sts_r <= '0;
		end else begin
			sa_sts_r <= sa_sts_nxt;
			ez_sts_r <= ez_sts_nxt;
		end
	end

	// Level output, high while an enabled status bit is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (|(sa_sts_nxt & sa_en_r)) | (|(ez_sts_nxt & ez_en_r));
		end
	end

	// ********************************
	// Assertions
	// ********************************

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Debounced nibble moves only after repeated identical samples
	deb_source_a: assert property ($changed(deb_r) |-> $past(rx.sa6_valid) &&
		$past(rx.sa6) == deb_r && $past(raw_r) == deb_r) else $error("debounced nibble changed without repeat");
	deb_hold_a: assert property (!rx.sa6_valid |=> $stable(deb_r))
		else $error("debounced nibble moved without a sample");

	// Entry into and exit from patterns a, b and zero, entry into c, and each new unmatched nibble are latched
	pat_a_latch_a: assert property (hit_now[BIT_PAT_A] != hit_old[BIT_PAT_A] |=> sa_sts_r[BIT_PAT_A])
		else $error("pattern a change not latched");
	pat_b_latch_a: assert property (hit_now[BIT_PAT_B] != hit_old[BIT_PAT_B] |=> sa_sts_r[BIT_PAT_B])
		else $error("pattern b change not latched");
	pat_c_latch_a: assert property ($changed(deb_r[3:1]) && deb_r[3:1] == PAT_C[3:1]
		|-> ##2 sa_sts_r[BIT_PAT_C]) else $error("pattern c entry not latched");
	other_latch_a: assert property ($changed(deb_r) && hit_now[BIT_OTHER] |=> sa_sts_r[BIT_OTHER])
		else $error("unmatched nibble not latched");
	zero_latch_a: assert property ($changed(deb_r == PAT_ZERO) |=> sa_sts_r[BIT_ZERO])
		else $error("zero nibble change not latched");

	// Enables load at the completing edge of their own write and hold while no write completes
	en_write_a: assert property (done && pwrite && idx == SA_EN_IDX |=> sa_en_r == $past(pwdata[SA_W-1:0]))
		else $error("sa6 enable write lost");
	ez_en_write_a: assert property (done && pwrite && idx == EZ_EN_IDX |=> ez_en_r == $past(pwdata[EZ_W-1:0]))
		else $error("sa7 and zero run enable write lost");
	en_hold_a: assert property (!(done && pwrite) |=> $stable(sa_en_r))
		else $error("sa6 enable moved without a write");
	ez_en_hold_a: assert property (!(done && pwrite) |=> $stable(ez_en_r))
		else $error("sa7 and zero run enable moved without a write");

	// A new zero next to an older zero declares the state two edges on
	sa7_state_a: assert property (rx.sa7_valid && !rx.sa7 && !(hist_r[1] & hist_r[0]) |-> ##2 sa7z_r)
		else $error("sa7 zero state not declared");
	sa7_release_a: assert property (rx.sa7_valid && rx.sa7 && (hist_r[1] | hist_r[0]) |-> ##2 !sa7z_r)
		else $error("sa7 zero state not released");
	hist_hold_a: assert property (!rx.sa7_valid |=> $stable(hist_r))
		else $error("sa7 history moved without a sample");

	// State changes are latched; a Sa7 state change also reaches the pin when enabled
	sa7_event_a: assert property ($changed(sa7z_r) |-> ez_sts_r[BIT_SA7_EVT] &&
		(irq_r || !$past(ez_en_r[BIT_SA7_EVT]))) else $error("sa7 change not latched");
	exz_event_a: assert property ($changed(exz_r) |-> ez_sts_r[BIT_EXZ_EVT])
		else $error("excess zero change not latched");

	// Reads and clear writes drop what was handed out or named, unless an event sets it again
	read_clear_a: assert property (done && !pwrite && idx == SA_STS_IDX |=>
		(sa_sts_r & $past(prdata_r[SA_W-1:0]) & ~$past(sa_evt)) == '0)
		else $error("status not cleared by read");
	ez_read_clear_a: assert property (done && !pwrite && idx == EZ_STS_IDX |=>
		(ez_sts_r & $past(prdata_r[EZ_W-1:0]) & ~$past(ez_evt)) == '0)
		else $error("zero run status not cleared by read");
	clr_write_a: assert property (done && pwrite && idx == SA_CLR_IDX |=>
		(sa_sts_r & $past(pwdata[SA_W-1:0]) & ~$past(sa_evt)) == '0)
		else $error("sa6 status not cleared by write");
	ez_clr_write_a: assert property (done && pwrite && idx == EZ_CLR_IDX |=>
		(ez_sts_r & $past(pwdata[EZ_W-1:0]) & ~$past(ez_evt)) == '0)
		else $error("zero run status not cleared by write");
	status_write_a: assert property (done && pwrite && idx == EZ_STS_IDX |=>
		ez_sts_r == ($past(ez_sts_r) | $past(ez_evt)))
		else $error("status write had an effect");

	// Latched bits fall only through a completed access
	sa_sticky_a: assert property ((|($past(sa_sts_r) & ~sa_sts_r)) |-> $past(done))
		else $error("sa6 status dropped without access");
	ez_sticky_a: assert property ((|($past(ez_sts_r) & ~ez_sts_r)) |-> $past(done))
		else $error("zero run status dropped without access");

	// ********************************
	// Bus checks
	// ********************************

	// One wait state, single-cycle answer, error only with ready
	pready_wait_a: assert property (acc && !pready_r |=> pready_r)
		else $error("access phase not answered");
	pready_pulse_a: assert property (pready_r |=> !pready_r)
		else $error("ready held for more than one cycle");
	slverr_qual_a: assert property (pslverr_r |-> pready_r)
		else $error("error without ready");
	unmapped_a: assert property (done && rd_err |-> pslverr_r && prdata_r == '0)
		else $error("unmapped access not refused");
	read_zero_a: assert property (done && !pwrite && (idx == SA_CLR_IDX || idx == EZ_CLR_IDX) |-> prdata_r == '0)
		else $error("clear register read not zero");

	// Pin is exactly the registered or of enabled status bits
	irq_gate_a: assert property (irq_r |-> (|(sa_sts_r & $past(sa_en_r))) || (|(ez_sts_r & $past(ez_en_r))))
		else $error("interrupt without enabled status");
	irq_level_a: assert property (irq_r == ((|(sa_sts_r & $past(sa_en_r))) ||
		(|(ez_sts_r & $past(ez_en_r)))))
		else $error("interrupt level wrong");

	// ********************************
	// Cover points
	// ********************************

	// Main scenarios the bench should reach
	read_clear_c: cover property (done && !pwrite && idx == SA_STS_IDX && prdata_r[SA_W-1:0] != '0);
	irq_rise_c: cover property ($rose(irq_r));
	sa7_toggle_c: cover property ($rose(sa7z_r) ##[1:40] $fell(sa7z_r));
	deb_change_c: cover property ($changed(deb_r) && hit_now[BIT_PAT_A]);
	exz_toggle_c: cover property ($changed(exz_r) && ez_en_r[BIT_EXZ_EVT]);
endmodule : e1nb_irq

/* File: core/e1nb_pkg.sv */
package e1nb_pkg;
	// ********************************
	// Behaviour
	// - With enable bit 4 set, entering or leaving debounced Sa6 = 1010 raises an interrupt.
	// - With enable bit 3 set, entering or leaving debounced Sa6 = 1000 raises an interrupt.
	// - With enable bit 2 set, entering or leaving debounced Sa6 = 001x (LSB ignored) raises an interrupt.
	// - With its enable set, a new debounced Sa6 value matching no monitored pattern raises an interrupt.
	// - With its enable set, entering or leaving debounced Sa6 = 0000 raises an interrupt.
	// - Each Sa6 enable bit is read/write, 1 enables, 0 disables, and resets to 0.
	// - Read-only bit 5 shows 1 while received Sa7 was 0 in at least 2 of the last 3 samples.
	// - Status bit 1 latches each assertion and each release of the Sa7-zero state.
	// - Status bit 0 latches each detection and each clearing of the excessive-zero condition.
	// - Latched status bits read 1 if the event happened since the last read, and clear on read.
	// - The interrupt output rises for an event only when that event's enable bit is set.
	// - Sa6 other and Sa6 0000 events sit at bits 1 and 0 of the Sa6 status register at 0x0B0C.
	// - Sa7 and excessive-zero enables are read/write bits 1 and 0 of their own register, reset 0.
	// ********************************

	// APB word index of each register; byte address is four times the index
	localparam int ADDR_W = 16;
	localparam logic [13:0] SA_STS_IDX = 14'h0b0c;
	localparam logic [13:0] SA_EN_IDX = 14'h0b0d;
	localparam logic [13:0] EZ_STS_IDX = 14'h0b0e;
	localparam logic [13:0] EZ_EN_IDX = 14'h0b0f;
	localparam logic [13:0] SA_CLR_IDX = 14'h0b10;
	localparam logic [13:0] EZ_CLR_IDX = 14'h0b11;

	// Field widths and positions
	localparam int SA_W = 5;
	localparam int EZ_W = 2;
	localparam int BIT_PAT_A = 4;
	localparam int BIT_PAT_B = 3;
	localparam int BIT_PAT_C = 2;
	localparam int BIT_OTHER = 1;
	localparam int BIT_ZERO = 0;
	localparam int BIT_SA7_STATE = 5;
	localparam int BIT_SA7_EVT = 1;
	localparam int BIT_EXZ_EVT = 0;

	// Sa6 patterns; pattern c ignores the least significant bit
	localparam logic [3:0] PAT_A = 4'ha;
	localparam logic [3:0] PAT_B = 4'h8;
	localparam logic [3:0] PAT_C = 4'h2;
	localparam logic [3:0] PAT_C_MASK = 4'he;
	localparam logic [3:0] PAT_ZERO = 4'h0;

	// Debounce depth and reset values
	localparam int DEB_CNT = 3;
	localparam logic [1:0] DEB_LAST = 2'(DEB_CNT - 1);
	localparam logic [3:0] SA6_RST = 4'hf;
	localparam logic [2:0] SA7_HIST_RST = 3'h7;
	localparam logic [SA_W-1:0] SA_EN_RST = 5'h00;
	localparam logic [EZ_W-1:0] EZ_EN_RST = 2'h0;

	// Samples handed over by the receive framer, same clock
	typedef struct packed {
		logic sa6_valid;
		logic [3:0] sa6;
		logic sa7_valid;
		logic sa7;
		logic exz;
	} e1nb_rx_t;
endpackage : e1nb_pkg

/* File: sim/e1nb_host_model.sv */
`timescale 1ns/100ps
module e1nb_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [e1nb_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import e1nb_pkg::*;
	// ********************************
	// Host side bus master
	// ********************************
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// One transfer; request held until pready, only the bench watchdog ends a dead wait
	task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = (pslverr !== 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : e1nb_host_model

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb;
	import e1nb_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	e1nb_rx_t rx;
	int n_errors, n_checks;
	logic [3:0] pat [7] = '{4'ha, 4'h8, 4'h3, 4'h2, 4'h0, 4'h5, 4'h7};
	logic [4:0] exp6 [7] = '{5'h10, 5'h18, 5'h0c, 5'h00, 5'h05, 5'h03, 5'h02};
	logic s7 [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic [5:0] exp7 [4] = '{6'h00, 6'h22, 6'h20, 6'h02};
	// 50 ns clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	e1nb_irq e1nb_irq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx), .irq(irq));
	e1nb_host_model e1nb_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ********************************
	// Helpers
	// ********************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [13:0] idx, input logic [31:0] d);
		e1nb_host_model_i.xfer(1'b1, idx, d, rd, err);
		chk("write error", 32'h0000_0000, 32'(err));
	endtask : wr
	task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input string what);
		e1nb_host_model_i.xfer(1'b0, idx, 32'h0000_0000, rd, err);
		chk("read error", 32'h0000_0000, 32'(err));
		chk(what, exp, rd);
	endtask : rdc
	// Three identical samples make a debounced value; wait covers the status latency
	task automatic sa6(input logic [3:0] v);
		repeat (3) begin
			@(posedge pclk);
			rx.sa6_valid <= 1'b1;
			rx.sa6 <= v;
		end
		@(posedge pclk);
		rx.sa6_valid <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : sa6
	task automatic sa7(input logic b);
		@(posedge pclk);
		rx.sa7_valid <= 1'b1;
		rx.sa7 <= b;
		@(posedge pclk);
		rx.sa7_valid <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : sa7
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// ********************************
	// Tests
	// ********************************
	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		#250000;
		n_errors++;
		wrap_up();
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		rx = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(SA_EN_IDX, 32'h0000_0000, "sa6 enable reset");
		rdc(EZ_EN_IDX, 32'h0000_0000, "ez enable reset");
		rdc(SA_STS_IDX, 32'h0000_0000, "sa6 status reset");
		rdc(EZ_STS_IDX, 32'h0000_0000, "ez status reset");
		wr(SA_EN_IDX, 32'h0000_00ff);
		rdc(SA_EN_IDX, 32'h0000_001f, "sa6 enable");
		wr(EZ_EN_IDX, 32'h0000_0003);
		rdc(EZ_EN_IDX, 32'h0000_0003, "ez enable");
		e1nb_host_model_i.xfer(1'b0, 14'h0b20, 32'h0000_0000, rd, err);
		chk("unmapped error", 32'h0000_0001, 32'(err));
		$display("test registers done");
		// Each step enters and leaves patterns; 0011 to 0010 stays inside 001x
		foreach (pat[i]) begin
			sa6(pat[i]);
			chk("irq sa6", 32'(|exp6[i]), 32'(irq));
			rdc(SA_STS_IDX, 32'(exp6[i]), "sa6 status");
			@(posedge pclk);
			chk("irq after read", 32'h0000_0000, 32'(irq));
		end
		rdc(SA_STS_IDX, 32'h0000_0000, "sa6 reread");
		wr(SA_EN_IDX, 32'h0000_0000);
		sa6(4'ha);
		chk("irq gated", 32'h0000_0000, 32'(irq));
		wr(SA_EN_IDX, 32'h0000_0010);
		repeat (2) @(posedge pclk);
		chk("irq enabled late", 32'h0000_0001, 32'(irq));
		wr(SA_CLR_IDX, 32'h0000_0010);
		repeat (2) @(posedge pclk);
		chk("irq after clear", 32'h0000_0000, 32'(irq));
		rdc(SA_STS_IDX, 32'h0000_0000, "sa6 cleared");
		$display("test sa6 done");
		// Two of three zeros declares the state, one zero left releases it
		foreach (s7[i]) begin
			sa7(s7[i]);
			chk("irq sa7", 32'(exp7[i][1]), 32'(irq));
			rdc(EZ_STS_IDX, 32'(exp7[i]), "sa7 status");
		end
		rx.exz <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("irq exz", 32'h0000_0001, 32'(irq));
		rdc(EZ_STS_IDX, 32'h0000_0001, "exz set");
		rx.exz <= 1'b0;
		repeat (3) @(posedge pclk);
		rdc(EZ_STS_IDX, 32'h0000_0001, "exz clear");
		wr(EZ_STS_IDX, 32'h0000_00ff);
		rdc(EZ_STS_IDX, 32'h0000_0000, "status write ignored");
		rx.exz <= 1'b1;
		repeat (3) @(posedge pclk);
		wr(EZ_CLR_IDX, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk("irq ez clear", 32'h0000_0000, 32'(irq));
		rdc(EZ_STS_IDX, 32'h0000_0000, "ez cleared");
		$display("test sa7 exz done");
		wrap_up();
	end
endmodule : tb
